// file: logic/lfs_regs.vh
/*
 * Constants for the link flow and stop command interpreter: command opcodes,
 * port register offsets, field positions, semaphore values and timing counts.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef LFS_REGS_VH
`define LFS_REGS_VH

// Command opcodes
`define LFS_OP_RESET        8'hff
`define LFS_OP_BUS8         8'h40
`define LFS_OP_BUS16        8'h41
`define LFS_OP_INIT         8'h42
`define LFS_OP_OFFLINE      8'h44
`define LFS_OP_ONLINE       8'h45
`define LFS_OP_RELOAD       8'h46
`define LFS_OP_STAT_DUMP    8'h23
`define LFS_OP_STAT_PRESET  8'h47
`define LFS_OP_IRQ_EN       8'h88
`define LFS_OP_RETIRE       8'h6a
`define LFS_OP_PEER_POLL    8'h69
`define LFS_OP_SET_BUSY     8'h61
`define LFS_OP_CLR_BUSY     8'h60
`define LFS_OP_STOP_I       8'h67
`define LFS_OP_HALT_SHARED  8'h89
`define LFS_OP_HALT_Q0      8'h8a
`define LFS_OP_HALT_Q1      8'h8b
`define LFS_OP_DIAG_DUMP    8'h20

// Register offsets on the host port
`define LFS_ADDR_CMD        4'h0
`define LFS_ADDR_ARG1       4'h1
`define LFS_ADDR_SEM        4'h2
`define LFS_ADDR_STATUS     4'h3
`define LFS_ADDR_BUSY       4'h4
`define LFS_ADDR_STOPPED    4'h5
`define LFS_ADDR_RETIRED    4'h6
`define LFS_ADDR_OUTST      4'h7

// Semaphore values
`define LFS_SEM_DONE        8'hff
`define LFS_SEM_BUSY        8'h00

// Status register field positions
`define LFS_ST_ONLINE       0
`define LFS_ST_BUS16        1
`define LFS_ST_IRQ_EN       2
`define LFS_ST_HALT_SHARED  3
`define LFS_ST_HALT_Q0      4
`define LFS_ST_HALT_Q1      5
`define LFS_ST_INIT_DONE    6
`define LFS_ST_STOP_WAIT    7

// Links and timing
`define LFS_LINKS           8
`define LFS_LINK_W          3
`define LFS_CLK_MHZ         50
`define LFS_ABORT_NS        100
`define LFS_ABORT_CYC       ((`LFS_ABORT_NS * `LFS_CLK_MHZ + 999) / 1000)

`endif

// file: logic/lfs_cmd_ctrl.v
/*
 * Command interpreter for link flow control and transmit stop commands.
 * Host writes arguments and an opcode on a plain register port and polls the
 * semaphore; the frame engines sit outside and see level controls and
 * one-cycle requests. Assumes one 50 MHz clock and a synchronous reset.
 */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "lfs_regs.vh"

module lfs_cmd_ctrl (
	input  wire        REF_CLK_I,
	input  wire        SYS_RST_I,
	input  wire [3:0]  ADDR_I,
	input  wire [7:0]  WDATA_I,
	input  wire        WR_I,
	input  wire        RD_I,
	input  wire [7:0]  POOL_EMPTY_I,
	input  wire [2:0]  TX_ACTIVE_I,
	input  wire [2:0]  TX_LINK_I,
	input  wire        TX_NUMBERED_I,
	input  wire [7:0]  OUTSTANDING_I,
	input  wire        XFER_DONE_I,
	input  wire        IRQ_I,
	output reg  [7:0]  RDATA_O,
	output reg  [7:0]  RX_BUSY_O,
	output reg  [7:0]  I_STOP_O,
	output reg  [2:0]  XIDUI_STOP_O,
	output reg         TX_ABORT_O,
	output reg         CONFIRM_O,
	output reg  [2:0]  CONFIRM_LINK_O,
	output reg         ONLINE_O,
	output reg         BUS16_O,
	output reg  [4:0]  XFER_REQ_O,
	output reg         POLL_REQ_O,
	output reg  [2:0]  POLL_LINK_O,
	output reg         IRQ_O
);

	localparam [7:0] ST_IDLE  = 8'h01;
	localparam [7:0] ST_BUSY  = 8'h02;
	localparam [7:0] ST_ABORT = 8'h04;
	localparam [7:0] ST_XFER  = 8'h08;
	localparam [7:0] ST_DONE  = 8'h10;

	// Window is counted in whole cycles; the count fits the four-bit counter
	localparam integer ABORT_CYC_N = `LFS_ABORT_CYC;
	localparam [3:0]   ABORT_CYC   = ABORT_CYC_N[3:0];

	// Transfer request bits towards the block mover
	localparam [2:0] XF_INIT   = 3'd0;
	localparam [2:0] XF_RELOAD = 3'd1;
	localparam [2:0] XF_SDUMP  = 3'd2;
	localparam [2:0] XF_SPRE   = 3'd3;
	localparam [2:0] XF_DDUMP  = 3'd4;

	reg  [7:0]  state_q;
	reg  [7:0]  state_d;
	reg  [7:0]  opcode_q;
	reg  [2:0]  link_q;
	reg  [7:0]  sem_q;
	reg  [7:0]  lbusy_q;
	reg  [7:0]  istop_q;
	reg  [7:0]  stop_wait_q;
	reg  [7:0]  retired_q;
	reg  [2:0]  xstop_q;
	reg  [3:0]  abort_cnt_q;
	reg         online_q;
	reg         bus16_q;
	reg         irq_en_q;
	reg         init_done_q;
	reg  [7:0]  status_w;
	reg  [2:0]  xq_sel;
	reg  [7:0]  conf_pick;
	reg         conf_hit;
	reg  [2:0]  conf_idx;
	reg  [7:0]  pool_busy_q;
	reg  [7:0]  clr_mask;
	reg         abort_hit;
	integer     k;

	wire cmd_wr = WR_I && (ADDR_I == `LFS_ADDR_CMD);
	wire take   = cmd_wr && (state_q == ST_IDLE);

	// Opcode to XID/UI queue select (bit 0 shared, 1 queue 0, 2 queue 1)
	always @* begin
		case (opcode_q)
			`LFS_OP_HALT_SHARED: xq_sel = 3'b001;
			`LFS_OP_HALT_Q0:     xq_sel = 3'b010;
			`LFS_OP_HALT_Q1:     xq_sel = 3'b100;
			default:             xq_sel = 3'b000;
		endcase
	end

	always @* begin
		status_w = 8'h00;
		status_w[`LFS_ST_ONLINE]      = online_q;
		status_w[`LFS_ST_BUS16]       = bus16_q;
		status_w[`LFS_ST_IRQ_EN]      = irq_en_q;
		status_w[`LFS_ST_HALT_SHARED] = xstop_q[0];
		status_w[`LFS_ST_HALT_Q0]     = xstop_q[1];
		status_w[`LFS_ST_HALT_Q1]     = xstop_q[2];
		status_w[`LFS_ST_INIT_DONE]   = init_done_q;
		status_w[`LFS_ST_STOP_WAIT]   = |stop_wait_q;
	end

	// Lowest stopped link whose numbered frames are all acknowledged
	always @* begin
		conf_pick = stop_wait_q & ~OUTSTANDING_I;
		conf_hit  = 1'b0;
		conf_idx  = 3'd0;
		for (k = `LFS_LINKS - 1; k >= 0; k = k - 1) begin
			if (conf_pick[k]) begin
				conf_hit = 1'b1;
				conf_idx = k[2:0];
			end
		end
	end

	// Link named by a clear-local-busy command while it executes
	always @* begin
		clr_mask = 8'h00;
		if (state_q == ST_BUSY && opcode_q == `LFS_OP_CLR_BUSY)
			clr_mask[link_q] = 1'b1;
	end

	// Frame in flight that the executing stop must drop; a frame started
	// later is held off by the stop flags rather than aborted
	always @* begin
		abort_hit = 1'b0;
		if (state_q == ST_BUSY) begin
			if (opcode_q == `LFS_OP_STOP_I && TX_NUMBERED_I &&
			    TX_ACTIVE_I[0] && TX_LINK_I == link_q)
				abort_hit = 1'b1;
			if (|(xq_sel & TX_ACTIVE_I) && !TX_NUMBERED_I)
				abort_hit = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:  if (take) state_d = ST_BUSY;
			ST_BUSY: begin
				if (|xq_sel)
					state_d = ST_ABORT;
				else if (opcode_q == `LFS_OP_INIT || opcode_q == `LFS_OP_RELOAD ||
				         opcode_q == `LFS_OP_STAT_DUMP ||
				         opcode_q == `LFS_OP_STAT_PRESET ||
				         opcode_q == `LFS_OP_DIAG_DUMP)
					state_d = ST_XFER;
				else
					state_d = ST_DONE;
			end
			// Give the frame engine a fixed window to drop a frame it is sending
			ST_ABORT: if (abort_cnt_q == 4'd1) state_d = ST_DONE;
			// No time limit: a mover that never answers leaves the semaphore at 00
			ST_XFER:  if (XFER_DONE_I) state_d = ST_DONE;
			ST_DONE:  state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			state_q     <= ST_IDLE;
			abort_cnt_q <= 4'd0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_BUSY)
				abort_cnt_q <= ABORT_CYC;
			else if (abort_cnt_q != 4'd0)
				abort_cnt_q <= abort_cnt_q - 4'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command registers and per-link state

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			opcode_q    <= 8'h00;
			link_q      <= 3'd0;
			sem_q       <= `LFS_SEM_DONE;
			lbusy_q     <= 8'h00;
			istop_q     <= 8'h00;
			stop_wait_q <= 8'h00;
			retired_q   <= 8'h00;
			xstop_q     <= 3'b000;
			online_q    <= 1'b0;
			bus16_q     <= 1'b0;
			irq_en_q    <= 1'b0;
			init_done_q <= 1'b0;
		end else begin
			// Host-side argument field; only link commands look at it
			if (WR_I && ADDR_I == `LFS_ADDR_ARG1 && state_q == ST_IDLE)
				link_q <= WDATA_I[2:0];
			// A command written while busy is dropped; semaphore guards it
			if (take) begin
				opcode_q <= WDATA_I;
				sem_q    <= `LFS_SEM_BUSY;
			end
			// Wait bit set by the executing stop wins over a same-cycle confirm clear
			if (conf_hit && state_q != ST_BUSY)
				stop_wait_q[conf_idx] <= 1'b0;
			if (state_q == ST_BUSY) begin
				case (opcode_q)
					`LFS_OP_SET_BUSY: lbusy_q[link_q] <= 1'b1;
					`LFS_OP_CLR_BUSY: lbusy_q[link_q] <= 1'b0;
					`LFS_OP_STOP_I: begin
						istop_q[link_q]     <= 1'b1;
						stop_wait_q[link_q] <= 1'b1;
						sem_q               <= `LFS_SEM_DONE;
					end
					`LFS_OP_RETIRE: begin
						retired_q[link_q] <= 1'b1;
						istop_q[link_q]   <= 1'b1;
					end
					`LFS_OP_HALT_SHARED,
					`LFS_OP_HALT_Q0,
					`LFS_OP_HALT_Q1:  xstop_q <= xstop_q | xq_sel;
					`LFS_OP_BUS8:     bus16_q <= 1'b0;
					`LFS_OP_BUS16:    bus16_q <= 1'b1;
					`LFS_OP_OFFLINE:  online_q <= 1'b0;
					`LFS_OP_ONLINE:   online_q <= 1'b1;
					`LFS_OP_IRQ_EN:   irq_en_q <= 1'b1;
					`LFS_OP_RESET: begin
						// Software reset returns every flag here to its power-up value; the pool busy latch reloads from POOL_EMPTY_I
						lbusy_q     <= 8'h00;
						istop_q     <= 8'h00;
						stop_wait_q <= 8'h00;
						retired_q   <= 8'h00;
						xstop_q     <= 3'b000;
						online_q    <= 1'b0;
						bus16_q     <= 1'b0;
						irq_en_q    <= 1'b0;
						init_done_q <= 1'b0;
					end
					default: ;
				endcase
			end
			if (state_q == ST_XFER && XFER_DONE_I && opcode_q == `LFS_OP_INIT)
				init_done_q <= 1'b1;
			// Interrupt output stays off after firing until re-enabled
			if (irq_en_q && IRQ_I && state_q != ST_BUSY)
				irq_en_q <= 1'b0;
			if (state_q == ST_DONE)
				sem_q <= `LFS_SEM_DONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Genuine receive busy

	// An empty pool latches busy for its link; refilling alone does not lift
	// it, only a clear-local-busy or a software reset does. A still empty pool wins that cycle.
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I)
			pool_busy_q <= 8'h00;
		else if (state_q == ST_BUSY && opcode_q == `LFS_OP_RESET)
			pool_busy_q <= POOL_EMPTY_I;
		else
			pool_busy_q <= POOL_EMPTY_I | (pool_busy_q & ~clr_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// Host read port

	// Read data stand for one cycle only and read zero otherwise
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= 8'h00;
			if (RD_I) begin
				case (ADDR_I)
					`LFS_ADDR_CMD:     RDATA_O <= opcode_q;
					`LFS_ADDR_ARG1:    RDATA_O <= {5'd0, link_q};
					`LFS_ADDR_SEM:     RDATA_O <= sem_q;
					`LFS_ADDR_STATUS:  RDATA_O <= status_w;
					`LFS_ADDR_BUSY:    RDATA_O <= RX_BUSY_O;
					`LFS_ADDR_STOPPED: RDATA_O <= istop_q;
					`LFS_ADDR_RETIRED: RDATA_O <= retired_q;
					`LFS_ADDR_OUTST:   RDATA_O <= OUTSTANDING_I;
					default:           RDATA_O <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Block mover requests

	// One pulse as the command starts; the mover ends it with a done pulse
	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			XFER_REQ_O <= 5'd0;
		end else begin
			XFER_REQ_O <= 5'd0;
			if (state_q == ST_BUSY) begin
				case (opcode_q)
					`LFS_OP_INIT:        XFER_REQ_O[XF_INIT]   <= 1'b1;
					`LFS_OP_RELOAD:      XFER_REQ_O[XF_RELOAD] <= 1'b1;
					`LFS_OP_STAT_DUMP:   XFER_REQ_O[XF_SDUMP]  <= 1'b1;
					`LFS_OP_STAT_PRESET: XFER_REQ_O[XF_SPRE]   <= 1'b1;
					`LFS_OP_DIAG_DUMP:   XFER_REQ_O[XF_DDUMP]  <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs

	always @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			RX_BUSY_O      <= 8'h00;
			I_STOP_O       <= 8'h00;
			XIDUI_STOP_O   <= 3'b000;
			TX_ABORT_O     <= 1'b0;
			CONFIRM_O      <= 1'b0;
			CONFIRM_LINK_O <= 3'd0;
			ONLINE_O       <= 1'b0;
			BUS16_O        <= 1'b0;
			POLL_REQ_O     <= 1'b0;
			POLL_LINK_O    <= 3'd0;
			IRQ_O          <= 1'b0;
		end else begin
			// Forced busy and latched no-buffer busy both hold the link
			RX_BUSY_O    <= lbusy_q | pool_busy_q;
			I_STOP_O     <= istop_q;
			XIDUI_STOP_O <= xstop_q;
			TX_ABORT_O   <= abort_hit;
			CONFIRM_O <= 1'b0;
			if (conf_hit && state_q != ST_BUSY) begin
				CONFIRM_O      <= 1'b1;
				CONFIRM_LINK_O <= conf_idx;
			end
			ONLINE_O <= online_q;
			BUS16_O  <= bus16_q;
			POLL_REQ_O <= 1'b0;
			if (state_q == ST_BUSY && opcode_q == `LFS_OP_PEER_POLL) begin
				POLL_REQ_O  <= online_q;
				POLL_LINK_O <= link_q;
			end
			IRQ_O <= irq_en_q & IRQ_I;
		end
	end

endmodule // lfs_cmd_ctrl

// file: tb/lfs_cmd_props.sv
/* Port checker for the command interpreter.
   Assumes one clock and a synchronous reset; bound onto lfs_cmd_ctrl. */
`timescale 1ns/100ps
module lfs_cmd_props (
	input wire       REF_CLK_I,
	input wire       SYS_RST_I,
	input wire [3:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire       WR_I,
	input wire [2:0] TX_ACTIVE_I,
	input wire [7:0] OUTSTANDING_I,
	input wire       IRQ_I,
	input wire [7:0] I_STOP_O,
	input wire       TX_ABORT_O,
	input wire       CONFIRM_O,
	input wire [2:0] CONFIRM_LINK_O,
	input wire       ONLINE_O,
	input wire [4:0] XFER_REQ_O,
	input wire       POLL_REQ_O,
	input wire       IRQ_O
);
	reg stop_wr_q;
	always @(posedge REF_CLK_I) begin
		stop_wr_q <= WR_I && ADDR_I == 4'h0 && (WDATA_I == 8'h67 || WDATA_I == 8'h6a);
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	abort_cause_a: assert property (TX_ABORT_O |->
		$past(TX_ACTIVE_I) != 3'h0 || $past(TX_ACTIVE_I, 2) != 3'h0) else $error("abort idle");
	abort_pulse_a: assert property (TX_ABORT_O |=> !TX_ABORT_O) else $error("abort long");
	confirm_cause_a: assert property (CONFIRM_O |->
		(((I_STOP_O & ~$past(OUTSTANDING_I)) >> CONFIRM_LINK_O) & 8'h01) != 8'h00)
		else $error("confirm early");
	confirm_pulse_a: assert property (CONFIRM_O |=> !CONFIRM_O) else $error("confirm long");
	stop_cause_a: assert property ((I_STOP_O & ~$past(I_STOP_O)) != 8'h00 |->
		$past(stop_wr_q) || $past(stop_wr_q, 2)) else $error("stop uncaused");
	poll_online_a: assert property (POLL_REQ_O |-> ONLINE_O || $past(ONLINE_O))
		else $error("poll offline");
	irq_gate_a: assert property (IRQ_O |-> $past(IRQ_I)) else $error("irq uncaused");
	xfer_pulse_a: assert property (XFER_REQ_O != 5'h00 |->
		$onehot(XFER_REQ_O) ##1 XFER_REQ_O == 5'h00) else $error("xfer bad");
	cover property (CONFIRM_O);
	cover property (TX_ABORT_O);
	cover property (POLL_REQ_O);
endmodule // lfs_cmd_props
////////////////////////////////////////////////////////////////////////////////
bind lfs_cmd_ctrl lfs_cmd_props u_lfs_cmd_props (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .TX_ACTIVE_I(TX_ACTIVE_I),
	.OUTSTANDING_I(OUTSTANDING_I), .IRQ_I(IRQ_I), .I_STOP_O(I_STOP_O),
	.TX_ABORT_O(TX_ABORT_O), .CONFIRM_O(CONFIRM_O), .CONFIRM_LINK_O(CONFIRM_LINK_O),
	.ONLINE_O(ONLINE_O), .XFER_REQ_O(XFER_REQ_O), .POLL_REQ_O(POLL_REQ_O), .IRQ_O(IRQ_O));

// file: tb/lfs_far_model.sv
/* Frame engine and block mover model on the far side.
   Assumes the bench loads frames via ld_i and sets the mover delay. */
`timescale 1ns/100ps
module lfs_far_model (
	input wire       clk_i,
	input wire       ld_i,
	input wire [2:0] act_i,
	input wire [2:0] lnk_i,
	input wire       num_i,
	input wire [3:0] dly_i,
	input wire       abort_i,
	input wire [4:0] xreq_i,
	output reg [2:0] act_o,
	output reg [2:0] lnk_o,
	output reg       num_o,
	output reg       done_o
);
	reg [3:0] cnt_q;
	initial begin
		act_o = 3'h0;
		lnk_o = 3'h0;
		num_o = 1'b0;
		done_o = 1'b0;
		cnt_q = 4'h0;
	end
	always @(posedge clk_i) begin
		done_o <= cnt_q == 4'h1;
		if (xreq_i != 5'h00)
			cnt_q <= dly_i;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
		if (ld_i) begin
			act_o <= act_i;
			lnk_o <= lnk_i;
			num_o <= num_i;
		end else if (abort_i)
			act_o <= 3'h0;
		// No frame: link lines wander so a stale value is never trusted
		if (!ld_i && act_o == 3'h0)
			lnk_o <= ~lnk_o;
	end
endmodule // lfs_far_model

// file: tb/test_link_flow_stop_commands.sv
/* Self-checking bench for the command interpreter.
   Assumes the bench acts as host; the far model stands for the engines. */
`timescale 1ns/100ps
`include "lfs_regs.vh"
module test_link_flow_stop_commands;
	reg        clk, rst, wr, rd, ld, num, irq;
	reg  [3:0] addr, dly;
	reg  [7:0] wdata, pool, outst, rdata, n_abort, n_conf, n_poll;
	reg  [2:0] act, lnk, conf_seen, poll_seen;
	reg  [4:0] xseen;
	wire [7:0] rdat, rx_busy, i_stop;
	wire [2:0] xs_stop, conf_lnk, poll_lnk, tx_act, tx_lnk;
	wire       abort, conf, online, bus16, poll, irq_o, tx_num, xdone;
	wire [4:0] xreq;
	integer    errors, compares, i;
	lfs_cmd_ctrl u_lfs_cmd_ctrl (.REF_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .POOL_EMPTY_I(pool), .TX_ACTIVE_I(tx_act),
		.TX_LINK_I(tx_lnk), .TX_NUMBERED_I(tx_num), .OUTSTANDING_I(outst),
		.XFER_DONE_I(xdone), .IRQ_I(irq), .RDATA_O(rdat), .RX_BUSY_O(rx_busy),
		.I_STOP_O(i_stop), .XIDUI_STOP_O(xs_stop), .TX_ABORT_O(abort), .CONFIRM_O(conf),
		.CONFIRM_LINK_O(conf_lnk), .ONLINE_O(online), .BUS16_O(bus16), .XFER_REQ_O(xreq),
		.POLL_REQ_O(poll), .POLL_LINK_O(poll_lnk), .IRQ_O(irq_o));
	lfs_far_model u_lfs_far_model (.clk_i(clk), .ld_i(ld), .act_i(act), .lnk_i(lnk),
		.num_i(num), .dly_i(dly), .abort_i(abort), .xreq_i(xreq), .act_o(tx_act),
		.lnk_o(tx_lnk), .num_o(tx_num), .done_o(xdone));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (abort === 1'b1) n_abort <= n_abort + 8'h01;
		if (conf === 1'b1) begin
			n_conf <= n_conf + 8'h01;
			conf_seen <= conf_lnk;
		end
		if (poll === 1'b1) begin
			n_poll <= n_poll + 8'h01;
			poll_seen <= poll_lnk;
		end
		xseen <= xseen | xreq;
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// Strobe tasks start and end on a rising edge; the idle gap avoids a double drive
	task wr_reg(input [3:0] a, input [7:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd_reg(input [3:0] a, output [7:0] d);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 d = rdat;
			@(posedge clk);
		end
	endtask
	task cmd(input [7:0] op, input [2:0] l);
		integer k;
		begin
			wr_reg(`LFS_ADDR_ARG1, {5'h00, l});
			wr_reg(`LFS_ADDR_CMD, op);
			rdata = 8'h00;
			for (k = 0; k < 40 && rdata !== `LFS_SEM_DONE; k = k + 1)
				rd_reg(`LFS_ADDR_SEM, rdata);
			chk(rdata, `LFS_SEM_DONE);
		end
	endtask
	task t_busy;
		begin
			cmd(`LFS_OP_SET_BUSY, 3'h3);
			chk(rx_busy, 8'h08);
			rd_reg(`LFS_ADDR_BUSY, rdata);
			chk(rdata, 8'h08);
			cmd(`LFS_OP_CLR_BUSY, 3'h3);
			chk(rx_busy, 8'h00);
			pool <= 8'h20;
			for (i = 0; i < 10 && rx_busy !== 8'h20; i = i + 1)
				@(negedge clk);
			@(posedge clk);
			chk(rx_busy, 8'h20);
			pool <= 8'h00;
			repeat (3) @(posedge clk);
			chk(rx_busy, 8'h20);
			cmd(`LFS_OP_CLR_BUSY, 3'h5);
			chk(rx_busy, 8'h00);
			rd_reg(`LFS_ADDR_SEM, rdata);
			chk(rdata, `LFS_SEM_DONE);
			$display("busy test done");
		end
	endtask
	task t_stop;
		begin
			outst <= 8'h04;
			act <= 3'h1;
			lnk <= 3'h2;
			num <= 1'b1;
			ld <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			cmd(`LFS_OP_STOP_I, 3'h2);
			chk(i_stop, 8'h04);
			chk(n_abort, 8'h01);
			chk(n_conf, 8'h00);
			outst <= 8'h00;
			for (i = 0; i < 20 && n_conf == 8'h00; i = i + 1)
				@(negedge clk);
			@(posedge clk);
			chk(n_conf, 8'h01);
			chk({5'h00, conf_seen}, 8'h02);
			$display("stop test done");
		end
	endtask
	task t_halt;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				act <= 3'h1 << i;
				num <= 1'b0;
				ld <= 1'b1;
				@(posedge clk);
				ld <= 1'b0;
				cmd(`LFS_OP_HALT_SHARED + i[7:0], 3'h0);
				chk({5'h00, xs_stop}, (8'h02 << i) - 8'h01);
				chk(n_abort, 8'h02 + i[7:0]);
			end
			$display("halt test done");
		end
	endtask
	task t_misc;
		begin
			cmd(`LFS_OP_BUS16, 3'h0);
			chk({7'h00, bus16}, 8'h01);
			cmd(`LFS_OP_BUS8, 3'h0);
			chk({7'h00, bus16}, 8'h00);
			cmd(`LFS_OP_ONLINE, 3'h0);
			chk({7'h00, online}, 8'h01);
			cmd(`LFS_OP_PEER_POLL, 3'h4);
			chk({n_poll[4:0], poll_seen}, 8'h0c);
			cmd(`LFS_OP_RETIRE, 3'h6);
			rd_reg(`LFS_ADDR_RETIRED, rdata);
			chk(rdata, 8'h40);
			dly <= 4'h9;
			cmd(`LFS_OP_INIT, 3'h0);
			cmd(`LFS_OP_RELOAD, 3'h0);
			cmd(`LFS_OP_STAT_DUMP, 3'h0);
			cmd(`LFS_OP_STAT_PRESET, 3'h0);
			cmd(`LFS_OP_DIAG_DUMP, 3'h0);
			chk({3'h0, xseen}, 8'h1f);
			rd_reg(`LFS_ADDR_STATUS, rdata);
			chk(rdata, 8'h79);
			cmd(`LFS_OP_IRQ_EN, 3'h0);
			irq <= 1'b1;
			@(posedge clk);
			@(negedge clk);
			chk({7'h00, irq_o}, 8'h01);
			@(posedge clk);
			irq <= 1'b0;
			rd_reg(4'hf, rdata);
			chk(rdata, 8'h00);
			cmd(`LFS_OP_OFFLINE, 3'h0);
			chk({7'h00, online}, 8'h00);
			cmd(`LFS_OP_PEER_POLL, 3'h4);
			chk(n_poll, 8'h01);
			cmd(`LFS_OP_RESET, 3'h0);
			chk(i_stop | {5'h00, xs_stop}, 8'h00);
			$display("misc test done");
		end
	endtask
	task finish_test;
		begin
			$display("errors=%0d compares=%0d", errors, compares);
			if (errors == 0 && compares > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#100000;
		errors = errors + 1;
		finish_test;
	end
	initial begin
		{rst, wr, rd, ld, num, irq} = 6'h20;
		{addr, dly, wdata, pool, outst, act, lnk} = 38'h0;
		{n_abort, n_conf, n_poll, xseen} = 29'h0;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_busy;
		t_stop;
		t_halt;
		t_misc;
		finish_test;
	end
endmodule // test_link_flow_stop_commands
